// ---- rtl/phy_page0_counters_pcs_cfg.sv ----
// Page selector, false-carrier and receive-error counters and the
// 100 Mb/s coding-sublayer configuration of one port, AXI4-Lite slave.
// Assumes event inputs come from logic on clk; the fiber strap is a pin.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module phy_page0_counters_pcs_cfg #(
  parameter int unsigned DESC_SHORT_CYC = phy_page0_pkg::DESC_SHORT_CYC,
  parameter int unsigned DESC_LONG_CYC  = phy_page0_pkg::DESC_LONG_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        false_carrier_evt,
  input  wire logic        rx_error,
  input  wire logic        carrier_valid,
  input  wire logic        invalid_symbol,
  input  wire logic        collision,
  input  wire logic        signal_level_ok,
  input  wire logic        descrambler_sync,
  input  wire logic        fiber_strap,
  output logic             rx_clk_free,
  output logic             true_quiet,
  output logic             signal_detect_force,
  output logic             fiber_mode_enable,
  output logic             desc_locked,
  output logic             link_up,
  output logic             irq
);

  phy_page0_pkg::state_s s_ff;
  phy_page0_pkg::state_s nxt_s;

  logic rd_hs;
  logic wr_go;
  logic in_window;
  logic rd_fc;
  logic rd_rec;
  logic rd_stat;
  logic rec_inc;
  logic sd_ok;
  logic [7:0] fc_base;
  logic [7:0] rec_base;
  logic [1:0] stat_base;
  logic [17:0] reload_cyc;

  function automatic logic [7:0] sat_inc(input logic [7:0] c);
    sat_inc = (c == phy_page0_pkg::CNT_MAX) ? c : c + 8'h01;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [1:0]  strb,
                                        input logic [15:0] rw_mask);
    logic [15:0] lane;
    lane  = {{8{strb[1]}}, {8{strb[0]}}} & rw_mask;
    merge = (old_v & ~lane) | (new_v & lane);
  endfunction

  function automatic logic upper_win(input logic [5:0] idx);
    upper_win = (idx >= phy_page0_pkg::IDX_WINDOW_LO) &&
                (idx <= phy_page0_pkg::IDX_WINDOW_HI);
  endfunction

  // Read value and response for one index
  function automatic logic [17:0] rd_val(input logic [5:0] idx,
                                         input phy_page0_pkg::state_s st);
    logic [15:0] d;
    logic [1:0]  r;
    d = 16'h0000;
    r = phy_page0_pkg::RESP_OKAY;
    if (upper_win(idx) && st.page != phy_page0_pkg::PAGE_EXTENDED0) begin
      d = 16'h0000;
    end else if (idx == phy_page0_pkg::IDX_PAGE_SELECT) begin
      d = {14'h0000, st.page};
    end else if (idx == phy_page0_pkg::IDX_FALSE_CARRIER) begin
      d = {8'h00, st.fc_cnt};
    end else if (idx == phy_page0_pkg::IDX_RX_ERROR) begin
      d = {8'h00, st.rec_cnt};
    end else if (idx == phy_page0_pkg::IDX_CODING_CFG) begin
      d = st.cfg & phy_page0_pkg::CFG_RW_MASK;
    end else if (upper_win(idx)) begin
      d = 16'h0000;
    end else if (idx == phy_page0_pkg::IDX_INT_STATUS) begin
      d = {14'h0000, st.int_stat};
    end else if (idx == phy_page0_pkg::IDX_INT_MASK) begin
      d = {14'h0000, st.int_mask};
    end else if (idx == phy_page0_pkg::IDX_LINK_STATUS) begin
      d = {14'h0000, st.locked, st.link_up};
    end else begin
      r = phy_page0_pkg::RESP_DECERR;
    end
    rd_val = {r, d};
  endfunction

  always_comb begin
    nxt_s = s_ff;
    rd_hs = arvalid && s_ff.arready;
    wr_go = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
    in_window = s_ff.page == phy_page0_pkg::PAGE_EXTENDED0;
    rd_fc  = rd_hs && in_window &&
             araddr[7:2] == phy_page0_pkg::IDX_FALSE_CARRIER;
    rd_rec = rd_hs && in_window &&
             araddr[7:2] == phy_page0_pkg::IDX_RX_ERROR;
    rd_stat = rd_hs && araddr[7:2] == phy_page0_pkg::IDX_INT_STATUS;

    // Write address and data taken in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_have   = 1'b1;
      nxt_s.awready   = 1'b0;
      nxt_s.waddr_idx = awaddr[7:2];
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wready = 1'b0;
      nxt_s.wdata  = wdata[15:0];
      nxt_s.wstrb  = wstrb[1:0];
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid  = 1'b0;
      nxt_s.awready = 1'b1;
      nxt_s.wready  = 1'b1;
    end

    // Clear on read comes first, so an event in that cycle still counts
    fc_base = rd_fc ? 8'h00 : s_ff.fc_cnt;
    nxt_s.fc_cnt = false_carrier_evt ? sat_inc(fc_base) : fc_base;
    rec_inc = rx_error && carrier_valid && !collision &&
              (s_ff.rec_sym_seen || invalid_symbol) &&
              !s_ff.rec_done;
    rec_base = rd_rec ? 8'h00 : s_ff.rec_cnt;
    nxt_s.rec_cnt = rec_inc ? sat_inc(rec_base) : rec_base;
    nxt_s.rec_sym_seen = carrier_valid &&
                         (s_ff.rec_sym_seen || invalid_symbol);
    nxt_s.rec_done = carrier_valid && (s_ff.rec_done || rec_inc);

    // Half-full marks the step from 7Fh to 80h
    stat_base = rd_stat ? 2'b00 : s_ff.int_stat;
    nxt_s.int_stat = stat_base;
    if (false_carrier_evt && fc_base == phy_page0_pkg::CNT_HALF_PREV) begin
      nxt_s.int_stat[phy_page0_pkg::INT_FC_HALF] = 1'b1;
    end
    if (rec_inc && rec_base == phy_page0_pkg::CNT_HALF_PREV) begin
      nxt_s.int_stat[phy_page0_pkg::INT_RE_HALF] = 1'b1;
    end

    if (wr_go) begin
      nxt_s.bvalid  = 1'b1;
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have  = 1'b0;
      nxt_s.bresp   = phy_page0_pkg::RESP_OKAY;
      if (s_ff.waddr_idx == phy_page0_pkg::IDX_PAGE_SELECT) begin
        nxt_s.page = 2'(merge({14'h0000, s_ff.page}, s_ff.wdata,
                              s_ff.wstrb, 16'h0003));
      end else if (upper_win(s_ff.waddr_idx) && !in_window) begin
        nxt_s.bresp = phy_page0_pkg::RESP_OKAY;
      end else if (s_ff.waddr_idx == phy_page0_pkg::IDX_CODING_CFG) begin
        nxt_s.cfg = merge(s_ff.cfg, s_ff.wdata, s_ff.wstrb,
                          phy_page0_pkg::CFG_RW_MASK);
      end else if (upper_win(s_ff.waddr_idx)) begin
        nxt_s.bresp = phy_page0_pkg::RESP_OKAY;
      end else if (s_ff.waddr_idx == phy_page0_pkg::IDX_INT_MASK) begin
        nxt_s.int_mask = 2'(merge({14'h0000, s_ff.int_mask}, s_ff.wdata,
                                  s_ff.wstrb, 16'h0003));
      end else if (s_ff.waddr_idx == phy_page0_pkg::IDX_INT_STATUS ||
                   s_ff.waddr_idx == phy_page0_pkg::IDX_LINK_STATUS) begin
        nxt_s.bresp = phy_page0_pkg::RESP_OKAY;
      end else begin
        nxt_s.bresp = phy_page0_pkg::RESP_DECERR;
      end
    end

    if (rd_hs) begin
      nxt_s.arready = 1'b0;
      nxt_s.rvalid  = 1'b1;
      {nxt_s.rresp, nxt_s.rdata} = rd_val(araddr[7:2], s_ff);
    end
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid  = 1'b0;
      nxt_s.arready = 1'b1;
    end

    // Strap caught only after two sync stages have filled
    nxt_s.strap_sync = {s_ff.strap_sync[0], fiber_strap};
    case (s_ff.strap_st)
      phy_page0_pkg::STRAP_WAIT0: nxt_s.strap_st = phy_page0_pkg::STRAP_WAIT1;
      phy_page0_pkg::STRAP_WAIT1: nxt_s.strap_st = phy_page0_pkg::STRAP_LOAD;
      phy_page0_pkg::STRAP_LOAD: begin
        nxt_s.cfg[phy_page0_pkg::CFG_FIBER] = s_ff.strap_sync[1];
        nxt_s.strap_st = phy_page0_pkg::STRAP_DONE;
      end
      default: nxt_s.strap_st = phy_page0_pkg::STRAP_DONE;
    endcase

    // Lock lasts one timeout past the last good sync
    reload_cyc = s_ff.cfg[phy_page0_pkg::CFG_DESCRAMBLER_TIMEOUT_SEL] ?
                 DESC_LONG_CYC[17:0] : DESC_SHORT_CYC[17:0];
    if (descrambler_sync) begin
      nxt_s.lock_timer = reload_cyc;
    end else if (s_ff.lock_timer != 18'h00000) begin
      nxt_s.lock_timer = s_ff.lock_timer - 18'h00001;
    end
    nxt_s.locked = descrambler_sync || s_ff.lock_timer > 18'h00001;

    sd_ok = signal_level_ok || s_ff.cfg[phy_page0_pkg::CFG_SD_FORCE];
    if (!s_ff.link_up) begin
      nxt_s.link_up = sd_ok && s_ff.locked;
    end else if (!sd_ok) begin
      nxt_s.link_up = 1'b0;
    end else if (!s_ff.cfg[phy_page0_pkg::CFG_SIGNAL_DETECT_OPTION] && !s_ff.locked) begin
      nxt_s.link_up = 1'b0;
    end

    // Registered from next values so irq tracks status with no lag
    nxt_s.irq = |(nxt_s.int_stat & nxt_s.int_mask);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_ff <= phy_page0_pkg::STATE_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready             = s_ff.awready;
  assign wready              = s_ff.wready;
  assign bvalid              = s_ff.bvalid;
  assign bresp               = s_ff.bresp;
  assign arready             = s_ff.arready;
  assign rvalid              = s_ff.rvalid;
  assign rresp               = s_ff.rresp;
  assign rdata               = {16'h0000, s_ff.rdata};
  assign rx_clk_free         = s_ff.cfg[phy_page0_pkg::CFG_FREE_CLK];
  assign true_quiet          = s_ff.cfg[phy_page0_pkg::CFG_TRUE_QUIET];
  assign signal_detect_force = s_ff.cfg[phy_page0_pkg::CFG_SD_FORCE];
  assign fiber_mode_enable   = s_ff.cfg[phy_page0_pkg::CFG_FIBER];
  assign desc_locked         = s_ff.locked;
  assign link_up             = s_ff.link_up;
  assign irq                 = s_ff.irq;

  // Checks
  fc_inc_a: assert property (@(posedge clk) disable iff (!nrst)
    false_carrier_evt && !rd_fc && s_ff.fc_cnt != 8'hFF
    |=> s_ff.fc_cnt == $past(s_ff.fc_cnt) + 8'h01)
    else $error("false carrier count did not step");

  fc_sat_a: assert property (@(posedge clk) disable iff (!nrst)
    s_ff.fc_cnt == 8'hFF && !rd_fc |=> s_ff.fc_cnt == 8'hFF)
    else $error("false carrier count wrapped");

  rec_once_a: assert property (@(posedge clk) disable iff (!nrst)
    s_ff.rec_done && carrier_valid && !rd_rec
    |=> s_ff.rec_cnt == $past(s_ff.rec_cnt))
    else $error("receive error counted twice in one carrier");

  rec_coll_a: assert property (@(posedge clk) disable iff (!nrst)
    collision && !rd_rec |=> s_ff.rec_cnt == $past(s_ff.rec_cnt))
    else $error("receive error counted during collision");

  rec_sat_a: assert property (@(posedge clk) disable iff (!nrst)
    s_ff.rec_cnt == 8'hFF && !rd_rec |=> s_ff.rec_cnt == 8'hFF)
    else $error("receive error count wrapped");

  rd_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_fc && !false_carrier_evt
    |=> s_ff.fc_cnt == 8'h00 && rvalid && rdata[7:0] == $past(s_ff.fc_cnt))
    else $error("counter read did not return and clear");

  rsv_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    rvalid && $past(rd_hs) && $past(araddr[7:2]) == 6'h13
    |-> rdata[15:2] == 14'h0000)
    else $error("reserved page bits read nonzero");

  page_hide_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_hs && !in_window && upper_win(araddr[7:2])
    |=> rdata == 32'h00000000)
    else $error("page 0 visible on another page");

  opt0_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    link_up && !s_ff.cfg[8] && !desc_locked |=> !link_up)
    else $error("link held without lock in modified mode");

  opt1_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    link_up && s_ff.cfg[8] && signal_level_ok |=> link_up)
    else $error("link dropped while level valid");

  fc_half_a: assert property (@(posedge clk) disable iff (!nrst)
    false_carrier_evt && !rd_fc && !rd_stat && s_ff.fc_cnt == 8'h7F
    |=> s_ff.int_stat[1] && (irq || !s_ff.int_mask[1]))
    else $error("half-full not flagged");

  strap_a: assert property (@(posedge clk) disable iff (!nrst)
    s_ff.strap_st == phy_page0_pkg::STRAP_LOAD
    |=> fiber_mode_enable == $past(s_ff.strap_sync[1]))
    else $error("fiber strap not loaded");

  rsv_cfg_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_hs && in_window && araddr[7:2] == phy_page0_pkg::IDX_CODING_CFG
    |=> rdata[31:12] == 20'h00000 && rdata[5:0] == 6'h00)
    else $error("reserved config bits read nonzero");

  rec_inc_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_error && carrier_valid && !collision && s_ff.rec_sym_seen &&
    !s_ff.rec_done && !rd_rec && s_ff.rec_cnt != 8'hFF
    |=> s_ff.rec_cnt == $past(s_ff.rec_cnt) + 8'h01)
    else $error("receive error not counted");

  no_sym_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_error && !s_ff.rec_sym_seen && !invalid_symbol && !rd_rec
    |=> s_ff.rec_cnt == $past(s_ff.rec_cnt))
    else $error("receive error counted without invalid symbol");

  force_link_a: assert property (@(posedge clk) disable iff (!nrst)
    signal_detect_force && desc_locked && !link_up |=> link_up)
    else $error("forced signal detect did not raise link");

  rec_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_rec && !rx_error
    |=> s_ff.rec_cnt == 8'h00 && rdata[7:0] == $past(s_ff.rec_cnt))
    else $error("receive error read did not return and clear");

  wr_cov_c: cover property (@(posedge clk) disable iff (!nrst)
    bvalid && bready && bresp == 2'h0);
  rd_clr_c: cover property (@(posedge clk) disable iff (!nrst)
    rd_rec && s_ff.rec_cnt != 8'h00);
  link_c: cover property (@(posedge clk) disable iff (!nrst)
    !link_up ##1 link_up);
  irq_c: cover property (@(posedge clk) disable iff (!nrst) irq);
  fc_sat_c: cover property (@(posedge clk) disable iff (!nrst)
    s_ff.fc_cnt == 8'hFF && false_carrier_evt);

endmodule

`default_nettype wire

// ---- pkg/phy_page0_pkg.sv ----
// Constants, types and register map of the page-0 counter and
// coding-sublayer configuration slice of one transceiver port.
// Assumes one 125 MHz clock and an AXI4-Lite register bus.
package phy_page0_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PAGE_SELECT   = 6'h13;
  localparam logic [5:0] IDX_FALSE_CARRIER = 6'h14;
  localparam logic [5:0] IDX_RX_ERROR      = 6'h15;
  localparam logic [5:0] IDX_CODING_CFG    = 6'h16;
  localparam logic [5:0] IDX_WINDOW_LO     = 6'h14;
  localparam logic [5:0] IDX_WINDOW_HI     = 6'h1F;
  localparam logic [5:0] IDX_INT_STATUS    = 6'h20;
  localparam logic [5:0] IDX_INT_MASK      = 6'h21;
  localparam logic [5:0] IDX_LINK_STATUS   = 6'h22;

  // Page selector values
  localparam logic [1:0] PAGE_EXTENDED0 = 2'h0;
  localparam logic [1:0] PAGE_DIAG      = 2'h2;

  // Coding-sublayer configuration fields
  localparam int unsigned CFG_FREE_CLK  = 11;
  localparam int unsigned CFG_TRUE_QUIET = 10;
  localparam int unsigned CFG_SD_FORCE  = 9;
  localparam int unsigned CFG_SIGNAL_DETECT_OPTION = 8;
  localparam int unsigned CFG_DESCRAMBLER_TIMEOUT_SEL = 7;
  localparam int unsigned CFG_FIBER     = 6;
  localparam logic [15:0] CFG_RW_MASK   = 16'h0FC0;
  localparam logic [15:0] CFG_RESET     = 16'h0100;

  // Interrupt status, interrupt mask and link status fields
  localparam int unsigned INT_FC_HALF = 1;
  localparam int unsigned INT_RE_HALF = 0;
  localparam int unsigned LINK_UP_BIT = 0;
  localparam int unsigned LOCKED_BIT  = 1;

  // Counter limits
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [7:0] CNT_HALF_PREV = 8'h7F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Descrambler lock-loss timeouts, rounded down to whole cycles
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned DESC_SHORT_NS   = 722000;
  localparam int unsigned DESC_LONG_NS    = 2000000;
  localparam int unsigned DESC_SHORT_CYC  = DESC_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned DESC_LONG_CYC   = DESC_LONG_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    STRAP_WAIT0 = 4'h1,
    STRAP_WAIT1 = 4'h2,
    STRAP_LOAD  = 4'h4,
    STRAP_DONE  = 4'h8
  } strap_e;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_have;
    logic        w_have;
    logic [5:0]  waddr_idx;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [15:0] rdata;
    logic [1:0]  page;
    logic [7:0]  fc_cnt;
    logic [7:0]  rec_cnt;
    logic [15:0] cfg;
    logic        rec_sym_seen;
    logic        rec_done;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic        irq;
    logic [17:0] lock_timer;
    logic        locked;
    logic        link_up;
    logic [1:0]  strap_sync;
    strap_e      strap_st;
  } state_s;

  localparam state_s STATE_RESET = '{
    awready:  1'b1,
    wready:   1'b1,
    arready:  1'b1,
    cfg:      CFG_RESET,
    strap_st: STRAP_WAIT0,
    default:  '0
  };

endpackage

// ---- dv/phy_page0_counters_pcs_cfg_bench.sv ----
// Self-checking bench for the page-0 counter and coding-sublayer slice.
// Assumes the design's AXI4-Lite slave and its short lock timeouts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  err_count++; $display("FAIL %s exp %0h got %0h", nm, exp, got); end end

module phy_page0_counters_pcs_cfg_bench;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        fc_evt, rx_err, car, inv, col, lvl, dsync, strap;
  logic        free_clk, tq, sdf, fiber, locked, link, irq;
  logic [15:0] d, cf;
  int          err_count, n_tests, fc, re, ist;

  // Short lock timeouts keep the run brief
  phy_page0_counters_pcs_cfg #(.DESC_SHORT_CYC(20), .DESC_LONG_CYC(50))
    phy_page0_counters_pcs_cfg_inst (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .false_carrier_evt(fc_evt), .rx_error(rx_err), .carrier_valid(car),
    .invalid_symbol(inv), .collision(col), .signal_level_ok(lvl),
    .descrambler_sync(dsync), .fiber_strap(strap), .rx_clk_free(free_clk),
    .true_quiet(tq), .signal_detect_force(sdf), .fiber_mode_enable(fiber),
    .desc_locked(locked), .link_up(link), .irq(irq));

  always #4 clk = ~clk;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    $display("FAIL bus answer exp 1 got 0");
    tally_and_finish();
  endtask

  // Ready lines stay high: every answer is taken at the edge it shows
  task automatic wr(input logic [5:0] idx, input logic [15:0] v,
                    input logic [3:0] s = 4'hF);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (bvalid) begin
        rd_r = bresp;
        return;
      end
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [5:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rvalid) begin
        rd_d = rdata;
        rd_r = rresp;
        return;
      end
      if (arready) arvalid <= 1'b0;
    end
    hang();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic fc_pulse(input int k);
    repeat (k) begin
      fc_evt <= 1'b1;
      @(posedge clk);
      fc_evt <= 1'b0;
      @(posedge clk);
      if (fc == 127) ist |= 2;
      if (fc < 255) fc++;
    end
  endtask

  // One carrier event: optional invalid symbol, then ne error cycles
  task automatic carrier(input logic i, input logic c, input int ne);
    car <= 1'b1;
    col <= c;
    inv <= i;
    @(posedge clk);
    inv <= 1'b0;
    rx_err <= 1'b1;
    cyc(ne);
    rx_err <= 1'b0;
    car <= 1'b0;
    col <= 1'b0;
    cyc(2);
    if (i && !c) begin
      if (re == 127) ist |= 1;
      if (re < 255) re++;
    end
  endtask

  task automatic sync();
    dsync <= 1'b1;
    @(posedge clk);
    dsync <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("FAIL watchdog exp 0 got 1");
    tally_and_finish();
  end

  initial begin
    {clk, nrst, awvalid, wvalid, arvalid, awaddr, araddr} = '0;
    {wdata, wstrb, fc_evt, rx_err, car, inv, col, lvl, dsync} = '0;
    {bready, rready, strap} = 3'b111;
    {err_count, n_tests, fc, re, ist} = '0;
    void'($urandom(77582));
    cyc(6);
    nrst <= 1'b1;
    cyc(4);
    rd(phy_page0_pkg::IDX_CODING_CFG);
    `CHK("cfg reset", 32'h0140, rd_d)
    `CHK("fiber pin", 1'b1, fiber)
    repeat (4) begin
      d = 16'($urandom);
      cf = d & phy_page0_pkg::CFG_RW_MASK;
      wr(phy_page0_pkg::IDX_CODING_CFG, d);
      rd(phy_page0_pkg::IDX_CODING_CFG);
      `CHK("cfg rw", cf, rd_d)
      `CHK("free clk", d[11], free_clk)
      `CHK("true quiet", d[10], tq)
      `CHK("sd force", d[9], sdf)
      `CHK("fiber", d[6], fiber)
    end
    // Low byte lane only
    wr(phy_page0_pkg::IDX_CODING_CFG, 16'hFFFF, 4'h1);
    rd(phy_page0_pkg::IDX_CODING_CFG);
    `CHK("cfg strobe", (cf | 16'h00C0), rd_d)
    wr(phy_page0_pkg::IDX_PAGE_SELECT, 16'hFFFF);
    `CHK("page wr resp", phy_page0_pkg::RESP_OKAY, rd_r)
    rd(phy_page0_pkg::IDX_PAGE_SELECT);
    `CHK("page rw", 32'h3, rd_d)
    `CHK("page rd resp", phy_page0_pkg::RESP_OKAY, rd_r)
    wr(phy_page0_pkg::IDX_PAGE_SELECT, 16'h0000);
    fc_pulse($urandom_range(1, 20));
    for (int p = 1; p < 4; p++) begin
      wr(phy_page0_pkg::IDX_PAGE_SELECT, 16'(p));
      rd(phy_page0_pkg::IDX_FALSE_CARRIER);
      `CHK("hidden page", 32'h0, rd_d)
    end
    wr(phy_page0_pkg::IDX_PAGE_SELECT, 16'h0000);
    wr(phy_page0_pkg::IDX_FALSE_CARRIER, 16'hFFFF);
    rd(phy_page0_pkg::IDX_FALSE_CARRIER);
    `CHK("fc count", fc, rd_d)
    fc = 0;
    rd(phy_page0_pkg::IDX_FALSE_CARRIER);
    `CHK("fc cleared", fc, rd_d)
    wr(6'h3F, 16'hFFFF);
    `CHK("unmapped wr", phy_page0_pkg::RESP_DECERR, rd_r)
    rd(6'h3F);
    `CHK("unmapped rd", phy_page0_pkg::RESP_DECERR, rd_r)
    carrier(1'b1, 1'b1, 3);
    carrier(1'b0, 1'b0, 3);
    carrier(1'b1, 1'b0, 4);
    repeat (20) carrier(1'($urandom), 1'($urandom), $urandom_range(1, 4));
    rd(phy_page0_pkg::IDX_RX_ERROR);
    `CHK("re count", re, rd_d)
    re = 0;
    fc_pulse(300);
    rd(phy_page0_pkg::IDX_FALSE_CARRIER);
    `CHK("fc saturate", fc, rd_d)
    fc = 0;
    repeat (260) carrier(1'b1, 1'b0, 1);
    rd(phy_page0_pkg::IDX_RX_ERROR);
    `CHK("re saturate", re, rd_d)
    re = 0;
    `CHK("irq masked", 1'b0, irq)
    wr(phy_page0_pkg::IDX_INT_MASK, 16'h0002);
    cyc(2);
    `CHK("irq on", 1'b1, irq)
    rd(phy_page0_pkg::IDX_INT_STATUS);
    `CHK("int status", ist, rd_d)
    cyc(2);
    `CHK("irq off", 1'b0, irq)
    // Lock timer expiry tolerated while the level stays good
    wr(phy_page0_pkg::IDX_CODING_CFG, 16'h0100);
    lvl <= 1'b1;
    sync();
    cyc(3);
    `CHK("link up opt1", 1'b1, link)
    cyc(30);
    `CHK("lock short", 1'b0, locked)
    `CHK("link hold", 1'b1, link)
    lvl <= 1'b0;
    cyc(3);
    `CHK("link lvl drop", 1'b0, link)
    wr(phy_page0_pkg::IDX_CODING_CFG, 16'h0000);
    lvl <= 1'b1;
    sync();
    cyc(3);
    `CHK("link up opt0", 1'b1, link)
    cyc(30);
    `CHK("link lock drop", 1'b0, link)
    wr(phy_page0_pkg::IDX_CODING_CFG, 16'h0080);
    sync();
    cyc(40);
    `CHK("lock long on", 1'b1, locked)
    cyc(20);
    `CHK("lock long off", 1'b0, locked)
    wr(phy_page0_pkg::IDX_CODING_CFG, 16'h0200);
    lvl <= 1'b0;
    sync();
    cyc(3);
    `CHK("forced link", 1'b1, link)
    tally_and_finish();
  end
endmodule
`default_nettype wire
